// *** logic/otp_prog_pkg.sv ***
// Shared constants, states and pin bundle for the one-time-programmable memory programmer.
package otp_prog_pkg;

  // ----------------------------------------------------------------
  // Timing, all figures in ns at the 20 MHz system clock
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 50;     // Clock period
  localparam int PULSE_NOM_NS = 100000; // Nominal program pulse
  localparam int PULSE_MIN_NS = 95000;  // Shortest legal program pulse
  localparam int PULSE_MAX_NS = 105000; // Longest legal program pulse
  localparam int SETUP_NS     = 2000;   // Address, data, OE and supply setup/hold

  // Least time in whole cycles, never below one
  function automatic int cycCeil(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cycCeil

  localparam logic [11:0] PULSE_CYC     = 12'(PULSE_NOM_NS / CLK_NS); // 2000 cycles
  localparam logic [11:0] PULSE_MIN_CYC = 12'(cycCeil(PULSE_MIN_NS)); // Rounded up
  localparam logic [11:0] PULSE_MAX_CYC = 12'(PULSE_MAX_NS / CLK_NS); // Rounded down
  // Setup also covers output delay and the two input synchroniser stages
  localparam logic [11:0] SETUP_CYC     = 12'(cycCeil(SETUP_NS));

  // ----------------------------------------------------------------
  // Array geometry and retry policy
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 15;       // 32K locations
  localparam logic [14:0] FIRST_ADDR = 15'h0000; // Lowest location
  localparam logic [14:0] LAST_ADDR  = 15'h7fff; // Highest location
  localparam logic [3:0]  MAX_RETRY  = 4'ha;     // Extra pulses before failure

  // ----------------------------------------------------------------
  // Sequencer states, codes follow a Gray sequence in the order listed
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0, // Waiting for a job
    ST_PWRUP = 4'h1, // Supplies to programming levels
    ST_PSET  = 4'h3, // First pass: address and data setup
    ST_PULSE = 4'h2, // Chip enable low, program pulse
    ST_HOLD  = 4'h6, // Data hold after the pulse
    ST_VSET  = 4'h7, // Verify read settle
    ST_VCMP  = 4'h5, // Verify compare
    ST_RSET  = 4'h4, // Retry: data setup before another pulse
    ST_PDN   = 4'hc, // Supplies back to read levels
    ST_FSET  = 4'hd, // Final read settle
    ST_FCMP  = 4'hf, // Final compare
    ST_DONE  = 4'he, // Report result
    ST_IDSET = 4'ha, // Identification read settle
    ST_IDRD  = 4'hb  // Identification capture
  } state_t;

  // ----------------------------------------------------------------
  // Pins driven toward the memory
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [14:0] addr;       // Address lines
    logic        idModeLine; // High: identification voltage on the mode line
    logic        ceN;        // Chip enable, active low
    logic        oeN;        // Output enable, active low
    logic [7:0]  byteLines;  // Data driven onto the byte lines
    logic        byteOeN;    // Low while the byte lines are driven
    logic        vccProg;    // High: core supply at programming level
    logic        vppProg;    // High: programming supply at programming level
  } pins_t;

  localparam pins_t PINS_RESET = '{addr: 15'h0000, idModeLine: 1'b0, ceN: 1'b1,
                                   oeN: 1'b1, byteLines: 8'h00, byteOeN: 1'b1,
                                   vccProg: 1'b0, vppProg: 1'b0};

endpackage : otp_prog_pkg

// *** logic/phase_timer.sv ***
// Down-counter that times each phase of the programming sequence.
`timescale 1ns/10ps
module phase_timer
  import otp_prog_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Load and status
  input  wire logic        load,
  input  wire logic [11:0] loadVal,
  output logic             expired
);

  logic [11:0] cnt_q; // Cycles left in the phase
  logic [11:0] cnt_d; // Next count

  // ----------------------------------------------------------------
  // Next count: load wins, otherwise count down and stop at zero
  // ----------------------------------------------------------------
  always_comb begin
    if (load) begin
      cnt_d = loadVal;
    end else if (cnt_q != 12'h000) begin
      cnt_d = cnt_q - 12'h001;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // Count register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Phase ends on the cycle the count sits at zero
  assign expired = (cnt_q == 12'h000);

endmodule : phase_timer

// *** logic/otp_prog_seq.sv ***
// Programming, verify and identification sequencer for a 32K x 8 OTP memory.
`timescale 1ns/10ps
module otp_prog_seq
  import otp_prog_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Job requests, one-cycle pulses
  input  wire logic        start,
  input  wire logic        idReq,
  input  wire logic        idSel,
  // Source image lookup, same clock domain
  output logic [14:0]      srcAddr,
  input  wire logic [7:0]  srcData,
  // Job status
  output logic             busy,
  output logic             done,
  output logic             pass,
  output logic             fail,
  output logic [14:0]      failAddr,
  output logic [7:0]       idByte,
  output logic             idValid,
  // Memory pins
  output pins_t            pins,
  input  wire logic [7:0]  byteLinesIn
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_t      state_q, state_d;       // Sequencer state
  logic [14:0] addr_q, addr_d;         // Current location
  logic [3:0]  retry_q, retry_d;       // Extra pulses spent on this byte
  logic        pass1_q, pass1_d;       // High during the blind first pass
  logic        mism_q, mism_d;         // A final compare has failed
  logic        idSel_q, idSel_d;       // Identification byte chosen
  logic        busy_q, busy_d;         // Job in progress
  logic        done_q, done_d;         // Job finished pulse
  logic        pass_q, pass_d;         // Device passed
  logic        fail_q, fail_d;         // Device failed
  logic [14:0] failAddr_q, failAddr_d; // First failing location
  logic [7:0]  idByte_q, idByte_d;     // Captured identification byte
  logic        idValid_q, idValid_d;   // Identification byte pulse
  pins_t       pins_q, pins_d;         // Registered pin drive
  logic [7:0]  byteMeta_q;             // Synchroniser first stage
  logic [7:0]  byteSync_q;             // Synchroniser second stage
  logic        tmrLoad;                // Restart phase timer
  logic [11:0] tmrVal;                 // Phase length minus one
  logic        tmrDone;                // Phase elapsed
  logic        isLast;                 // At the highest location
  logic        match;                  // Read byte equals source byte

  assign isLast = (addr_q == LAST_ADDR);
  assign match  = (byteSync_q == srcData);

  // ----------------------------------------------------------------
  // Phase timer
  // ----------------------------------------------------------------
  phase_timer u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (tmrLoad),
    .loadVal (tmrVal),
    .expired (tmrDone)
  );

  // Restart on every state change; a phase lasts loadVal plus one cycles
  always_comb begin
    tmrLoad = (state_d != state_q);
    tmrVal  = (state_d == ST_PULSE) ? PULSE_CYC - 12'h001 : SETUP_CYC - 12'h001;
  end

  // ----------------------------------------------------------------
  // Byte line input synchroniser; the pins are asynchronous
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byteMeta_q <= 8'h00;
      byteSync_q <= 8'h00;
    end else begin
      byteMeta_q <= byteLinesIn;
      byteSync_q <= byteMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    addr_d     = addr_q;
    retry_d    = retry_q;
    pass1_d    = pass1_q;
    mism_d     = mism_q;
    idSel_d    = idSel_q;
    done_d     = 1'b0;
    pass_d     = pass_q;
    fail_d     = fail_q;
    failAddr_d = failAddr_q;
    idByte_d   = idByte_q;
    idValid_d  = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          // Fresh job from the lowest location
          state_d = ST_PWRUP;
          addr_d  = FIRST_ADDR;
          pass1_d = 1'b1;
          retry_d = 4'h0;
          mism_d  = 1'b0;
          pass_d  = 1'b0;
          fail_d  = 1'b0;
        end else if (idReq) begin
          state_d = ST_IDSET;
          idSel_d = idSel;
        end
      end
      // Supplies settle before the first pulse
      ST_PWRUP: if (tmrDone) state_d = ST_PSET;
      ST_PSET:  if (tmrDone) state_d = ST_PULSE;
      ST_RSET:  if (tmrDone) state_d = ST_PULSE;
      ST_PULSE: if (tmrDone) state_d = ST_HOLD;
      ST_HOLD: begin
        if (tmrDone) begin
          if (!pass1_q) begin
            state_d = ST_VSET;
          end else if (isLast) begin
            // Blind pass over, verify from the start
            pass1_d = 1'b0;
            addr_d  = FIRST_ADDR;
            state_d = ST_VSET;
          end else begin
            addr_d  = addr_q + 15'h0001;
            state_d = ST_PSET;
          end
        end
      end
      ST_VSET: if (tmrDone) state_d = ST_VCMP;
      ST_VCMP: begin
        if (match) begin
          retry_d = 4'h0;
          if (isLast) begin
            addr_d  = FIRST_ADDR;
            state_d = ST_PDN;
          end else begin
            addr_d  = addr_q + 15'h0001;
            state_d = ST_VSET;
          end
        end else if (retry_q == MAX_RETRY) begin
          // Give up on this device
          fail_d     = 1'b1;
          failAddr_d = addr_q;
          done_d     = 1'b1;
          state_d    = ST_DONE;
        end else begin
          retry_d = retry_q + 4'h1;
          state_d = ST_RSET;
        end
      end
      ST_PDN:  if (tmrDone) state_d = ST_FSET;
      ST_FSET: if (tmrDone) state_d = ST_FCMP;
      ST_FCMP: begin
        // Keep only the first failing location
        if (!match && !mism_q) begin
          failAddr_d = addr_q;
        end
        mism_d = mism_q | !match;
        if (isLast) begin
          pass_d  = !(mism_q | !match);
          fail_d  = mism_q | !match;
          done_d  = 1'b1;
          state_d = ST_DONE;
        end else begin
          addr_d  = addr_q + 15'h0001;
          state_d = ST_FSET;
        end
      end
      ST_DONE:  state_d = ST_IDLE;
      ST_IDSET: if (tmrDone) state_d = ST_IDRD;
      ST_IDRD: begin
        idByte_d  = byteSync_q;
        idValid_d = 1'b1;
        state_d   = ST_IDLE;
      end
      // Unused code: recover to idle
      default:  state_d = ST_IDLE;
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      addr_q     <= FIRST_ADDR;
      retry_q    <= 4'h0;
      pass1_q    <= 1'b0;
      mism_q     <= 1'b0;
      idSel_q    <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      pass_q     <= 1'b0;
      fail_q     <= 1'b0;
      failAddr_q <= FIRST_ADDR;
      idByte_q   <= 8'h00;
      idValid_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      addr_q     <= addr_d;
      retry_q    <= retry_d;
      pass1_q    <= pass1_d;
      mism_q     <= mism_d;
      idSel_q    <= idSel_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      pass_q     <= pass_d;
      fail_q     <= fail_d;
      failAddr_q <= failAddr_d;
      idByte_q   <= idByte_d;
      idValid_q  <= idValid_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, one cycle behind the state so every pin is a flop
  // ----------------------------------------------------------------
  always_comb begin
    pins_d           = PINS_RESET;
    pins_d.addr      = addr_q;
    pins_d.byteLines = srcData;
    unique case (state_q)
      ST_PWRUP: begin
        pins_d.vccProg = 1'b1;
        pins_d.vppProg = 1'b1;
      end
      ST_PSET, ST_RSET, ST_HOLD: begin
        // Data set up or held around the pulse, OE kept high
        pins_d.vccProg = 1'b1;
        pins_d.vppProg = 1'b1;
        pins_d.byteOeN = 1'b0;
      end
      ST_PULSE: begin
        pins_d.vccProg = 1'b1;
        pins_d.vppProg = 1'b1;
        pins_d.byteOeN = 1'b0;
        pins_d.ceN     = 1'b0;
      end
      ST_VSET, ST_VCMP: begin
        // Byte lines released; OE low but chip enable kept high
        pins_d.vccProg = 1'b1;
        pins_d.vppProg = 1'b1;
        pins_d.oeN     = 1'b0;
      end
      ST_FSET, ST_FCMP: begin
        // Plain read at normal supply levels
        pins_d.ceN = 1'b0;
        pins_d.oeN = 1'b0;
      end
      ST_IDSET, ST_IDRD: begin
        // Other address lines low, lowest line picks the byte
        pins_d.addr       = {14'h0000, idSel_q};
        pins_d.idModeLine = 1'b1;
        pins_d.ceN        = 1'b0;
        pins_d.oeN        = 1'b0;
      end
      default: ; // Idle, power-down and done: all inactive
    endcase
  end

  // Pin register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_q <= PINS_RESET;
    end else begin
      pins_q <= pins_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a register
  // ----------------------------------------------------------------
  assign srcAddr  = addr_q;
  assign busy     = busy_q;
  assign done     = done_q;
  assign pass     = pass_q;
  assign fail     = fail_q;
  assign failAddr = failAddr_q;
  assign idByte   = idByte_q;
  assign idValid  = idValid_q;
  assign pins     = pins_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [11:0] pulseCnt_q; // Cycles chip enable has been low for a pulse

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulseCnt_q <= 12'h000;
    end else if (!pins_q.ceN && pins_q.oeN) begin
      pulseCnt_q <= pulseCnt_q + 12'h001;
    end else begin
      pulseCnt_q <= 12'h000;
    end
  end

  a_pulse_width: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(pins_q.ceN) && $past(pins_q.oeN)) |->
      (pulseCnt_q >= PULSE_MIN_CYC && pulseCnt_q <= PULSE_MAX_CYC))
    else $error("program pulse width out of range");

  a_start_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_IDLE && start) |=> (addr_q == FIRST_ADDR) ##1 (pins_q.addr == FIRST_ADDR))
    else $error("programming did not start at lowest address");

  a_pulse_supply: assert property (@(posedge sys_clk) disable iff (rst)
    (!pins_q.ceN && pins_q.oeN) |-> (pins_q.vccProg && pins_q.vppProg && $past(pins_q.vppProg)))
    else $error("pulse without programming supplies");

  a_blind_pass: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_HOLD && pass1_q && tmrDone && !isLast) |=> ##40 (state_q == ST_PULSE)
      ##0 $stable(addr_q) ##0 pins_q.oeN)
    else $error("first pass read back or skipped a pulse");

  a_retry_bound: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_VCMP && !match && retry_q < MAX_RETRY) |=>
      (state_q == ST_RSET && retry_q == $past(retry_q) + 4'h1))
    else $error("retry not taken after mismatch");

  a_fail_stop: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_VCMP && !match && retry_q == MAX_RETRY) |=>
      (fail_q && done_q && state_q == ST_DONE) ##1 (state_q == ST_IDLE))
    else $error("failure after ten retries not reported");

  a_verify_next: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_VCMP && match && !isLast) |=>
      (addr_q == $past(addr_q) + 15'h0001 && retry_q == 4'h0 && state_q == ST_VSET))
    else $error("verify did not advance after match");

  a_final_read: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_FCMP) |-> (!pins_q.vccProg && !pins_q.vppProg && !pins_q.oeN))
    else $error("final compare not at read supply levels");

  a_verify_bus: assert property (@(posedge sys_clk) disable iff (rst)
    (!pins_q.oeN |-> pins_q.byteOeN) and ((!pins_q.ceN && pins_q.oeN) |-> !pins_q.byteOeN))
    else $error("byte lines contention or undriven during pulse");

  a_id_select: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == ST_IDRD) |-> (pins_q.idModeLine && pins_q.addr == {14'h0000, idSel_q})
      ##1 (idValid_q && idByte_q == $past(byteSync_q)))
    else $error("identification read set up wrongly");

endmodule : otp_prog_seq

// *** tb/otp_mem_model.sv ***
// Behavioural model of the 32K x 8 one-time-programmable memory at the far side.
`timescale 1ns/10ps
module otp_mem_model
  import otp_prog_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary maker byte
  parameter logic [7:0] DEV_CODE   = 8'ha7  // Arbitrary device byte
)
(
  // Pins from the programmer
  input  wire pins_t pins,
  // Byte lines as the memory drives them
  output logic [7:0] devOut
);
  // ----------------------------------------------------------------
  // Storage and read path
  // ----------------------------------------------------------------
  logic [7:0] mem [0:32767]; // Cell array, erased is all ones
  logic [7:0] readVal;       // Byte the memory would present
  logic [7:0] lastVal = 8'h00; // Last byte driven, kept to invert on release
  logic       driving;       // Chip and output enable both low

  // Erased array at power-on
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hff;
    end
  end

  // Program pulse clears bits only, as an OTP cell cannot be set back
  always @(negedge pins.ceN) begin
    if (pins.oeN && !pins.byteOeN && pins.vccProg && pins.vppProg) begin
      mem[pins.addr] = mem[pins.addr] & pins.byteLines;
    end
  end

  // Identification bytes replace the array when the mode line is high and address lines 14 to 1 are low
  always_comb begin
    driving = !pins.ceN && !pins.oeN;
    if (pins.idModeLine && pins.addr[14:1] == 14'h0000) begin
      readVal = pins.addr[0] ? DEV_CODE : MAKER_CODE;
    end else begin
      readVal = mem[pins.addr];
    end
  end

  // Released lines show the inverse of the last byte, never a stale copy
  always @(*) begin
    if (driving) begin
      devOut  = readVal;
      lastVal = readVal;
    end else begin
      devOut = ~lastVal;
    end
  end
endmodule : otp_mem_model

// *** tb/otp_prog_seq_bench.sv ***
// Self-checking bench for the OTP programming sequencer.
`timescale 1ns/10ps
module otp_prog_seq_bench;
  import otp_prog_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEV_CODE   = 8'ha7; // Arbitrary value
  logic        sys_clk;     // 20 MHz clock
  logic        rst;         // Async reset, active high
  logic        start;       // Program job request
  logic        idReq;       // Identification request
  logic        idSel;       // Identification byte select
  logic [14:0] srcAddr;     // Source image address
  logic [7:0]  srcData;     // Source image byte
  logic        busy, done, pass, fail, idValid;
  logic [14:0] failAddr;    // Failing location
  logic [7:0]  idByte;      // Captured identification byte
  pins_t       pins;        // Pins toward the memory
  logic [7:0]  devOut;      // Memory side of the byte lines
  logic [7:0]  byteLinesIn; // Resolved byte lines
  logic [31:0] lfsrState;   // Random source
  logic [7:0]  img [0:63];  // Source image, repeats every 64 bytes
  int          num_errors;
  int          n_tests;
  int          lowCnt, supCnt, pulseCnt, n;
  logic [14:0] nextAddr;    // Expected address of the next pulse
  logic        jobOn;       // Pulse monitor enabled

  // ----------------------------------------------------------------
  // Instances and wiring
  // ----------------------------------------------------------------
  otp_prog_seq dut_u (.sys_clk(sys_clk), .rst(rst), .start(start), .idReq(idReq),
    .idSel(idSel), .srcAddr(srcAddr), .srcData(srcData), .busy(busy), .done(done),
    .pass(pass), .fail(fail), .failAddr(failAddr), .idByte(idByte), .idValid(idValid),
    .pins(pins), .byteLinesIn(byteLinesIn));
  otp_mem_model #(.MAKER_CODE(MAKER_CODE), .DEV_CODE(DEV_CODE)) mem_u (.pins(pins),
    .devOut(devOut));
  // Host wins the lines only while its enable is low
  assign byteLinesIn = (pins.byteOeN === 1'b0) ? pins.byteLines : devOut;
  // Source byte follows the address in the same cycle
  assign srcData = img[srcAddr[5:0]];

  // Clock
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsrStep(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrStep

  function automatic logic [7:0] expId(input logic sel);
    return sel ? DEV_CODE : MAKER_CODE;
  endfunction : expId

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // All inputs move 2 ns after the rising edge
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask : tick

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Identification read, with a start that must be refused meanwhile
  task automatic idRead(input logic sel);
    int k;
    idSel = sel;
    idReq = 1'b1;
    tick();
    idReq = 1'b0;
    start = 1'b1;
    k = 0;
    while (idValid !== 1'b1 && k < 100) begin
      tick();
      start = 1'b0;
      k++;
      if (k == 2) begin
        check(32'({pins.idModeLine, pins.ceN, pins.oeN}), 32'h4);
        check(32'(pins.addr), 32'(sel));
      end
    end
    if (k >= 100) begin
      check(32'(k), 32'd41);
      tally_and_finish();
    end
    // Settle phase of 40 cycles, one capture cycle, then the pulse
    check(32'(k), 32'd41);
    check(32'(idByte), 32'(expId(sel)));
    tick();
    check(32'({idValid, busy}), 32'h0);
    $display("test id read sel=%0d done", sel);
  endtask : idRead

  // ----------------------------------------------------------------
  // Pulse monitor: width, address order, pin levels during pulses
  // ----------------------------------------------------------------
  // Sampled on the falling edge, well away from the launching edge
  always @(negedge sys_clk) begin
    if (jobOn) begin
      if (pins.vccProg === 1'b1 && pins.vppProg === 1'b1) supCnt++;
      if (pins.oeN !== 1'b1) check(32'(pins.oeN), 32'h1);
      if (pins.ceN === 1'b0) begin
        if (lowCnt == 0) begin
          check(32'(supCnt >= 40), 32'h1);
          check(32'({pins.vccProg, pins.vppProg}), 32'h3);
          check(32'(pins.addr), 32'(nextAddr));
          check(32'({pins.oeN, pins.byteOeN}), 32'h2);
          check(32'(pins.byteLines), 32'(img[pins.addr[5:0]]));
        end
        lowCnt++;
      end else if (lowCnt != 0) begin
        check(32'(lowCnt), 32'(PULSE_CYC));
        pulseCnt++;
        nextAddr++;
        lowCnt = 0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    start = 1'b0;
    idReq = 1'b0;
    idSel = 1'b0;
    num_errors = 0;
    n_tests = 0;
    lowCnt = 0;
    supCnt = 0;
    pulseCnt = 0;
    nextAddr = FIRST_ADDR;
    jobOn = 1'b0;
    lfsrState = 32'he904a372;
    for (int i = 0; i < 64; i++) begin
      lfsrState = lfsrStep(lfsrState);
      img[i] = lfsrState[7:0];
    end
    // Reset held two cycles, outputs at rest
    tick();
    tick();
    check(32'(pins), 32'(PINS_RESET));
    check(32'({busy, done, pass, fail, idValid}), 32'h0);
    check(32'({failAddr, idByte}), 32'h0);
    rst = 1'b0;
    $display("test reset done");
    // Both identification bytes, then random selections
    idRead(1'b0);
    idRead(1'b1);
    for (int i = 0; i < 4; i++) begin
      lfsrState = lfsrStep(lfsrState);
      idRead(lfsrState[0]);
    end
    // First programming pass; a second start mid-job must not disturb it
    jobOn = 1'b1;
    start = 1'b1;
    tick();
    start = 1'b0;
    check(32'(busy), 32'h1);
    for (n = 0; n < 60000 && pulseCnt < 20; n++) begin
      start = (n == 5000);
      tick();
    end
    check(32'(pulseCnt), 32'd20);
    if (pulseCnt < 20) tally_and_finish();
    // Erased cells ANDed with the image: each pulsed byte must now hold it
    for (int i = 0; i < 20; i++) begin
      check(32'(mem_u.mem[i]), 32'(img[i]));
    end
    $display("test first pass done");
    // Reset in mid-job drops supplies and strobes at once
    jobOn = 1'b0;
    rst = 1'b1;
    #5;
    check(32'(pins), 32'(PINS_RESET));
    check(32'({busy, done, pass, fail}), 32'h0);
    tick();
    tick();
    rst = 1'b0;
    $display("test mid-job reset done");
    idRead(1'b1);
    idRead(1'b0);
    tally_and_finish();
  end
endmodule : otp_prog_seq_bench
